// ===== bench/pcfd_monitor.sv
`timescale 1ns/1ns
module pcfd_monitor #(parameter int unsigned SYNC_CYCLES = 50) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic carrier_present,
    input wire pcfd_pkg::pcfd_analog_t analog_out,
    input wire pcfd_pkg::pcfd_digital_t digital_out,
    input wire logic read_strobe,
    input wire logic clear_strobe
);
    int rcnt;
    int ccnt;
    int hcnt;
    always_ff @(posedge clk_sys) rcnt <= (rst || !read_strobe) ? 0 : rcnt + 1;
    always_ff @(posedge clk_sys) ccnt <= (rst || !clear_strobe) ? 0 : ccnt + 1;
    always_ff @(posedge clk_sys) hcnt <= (rst || !carrier_present) ? 0 : hcnt + 1;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    read_width_a: assert property ($fell(read_strobe) |-> rcnt == 100) else $error("read width");
    clear_width_a: assert property ($fell(clear_strobe) |-> ccnt == 100) else $error("clear width");
    clear_follows_a: assert property ($fell(read_strobe) |-> clear_strobe) else $error("no clear");
    strobe_excl_a: assert property (!(read_strobe && clear_strobe)) else $error("both strobes");
    slot_excl_a: assert property (!(analog_out.slot1 && analog_out.slot2)) else $error("slots");
    slot_rise_a:
        assert property (($rose(analog_out.slot1) || $rose(analog_out.slot2)) |->
        $past(carrier_present, 3) && !$past(carrier_present, 2)) else $error("slot cause");
    digital_hold_a:
        assert property (!read_strobe && !$past(read_strobe) |-> $stable(digital_out))
        else $error("digital moved");
    sync_early_a:
        assert property ($rose(read_strobe) |-> hcnt >= SYNC_CYCLES &&
        hcnt <= SYNC_CYCLES + 4) else $error("sync timing");
    sync_miss_a: assert property (hcnt == SYNC_CYCLES + 6 |-> read_strobe) else $error("no sync");
    strobe_quiet_a:
        assert property (read_strobe |-> !analog_out.slot1 && !analog_out.slot2)
        else $error("slot in sync");
endmodule
bind pcfd_decoder pcfd_monitor #(.SYNC_CYCLES(SYNC_CYCLES)) pcfd_monitor_inst (.clk_sys(clk_sys),
    .rst(rst), .carrier_present(carrier_present), .analog_out(analog_out),
    .digital_out(digital_out), .read_strobe(read_strobe), .clear_strobe(clear_strobe));

// ===== bench/pcfd_tx_model.sv
`timescale 1ns/1ns
module pcfd_tx_model #(parameter int DROP = 5, parameter int SYNC = 80) (
    input wire logic clk_sys,
    output logic carrier_present
);
    initial carrier_present = 1'b1;
    task automatic slot(input int high);
        repeat (DROP) @(negedge clk_sys) carrier_present <= 1'b0;
        repeat (high) @(negedge clk_sys) carrier_present <= 1'b1;
    endtask
    task automatic send_frame(input int extra, input int w1, input int w2);
        slot(w1);
        slot(w2);
        repeat (extra) slot(DROP);
        slot(SYNC);
    endtask
endmodule

// ===== bench/test_pulse_count_frame_decoder.sv
`timescale 1ns/1ns
module test_pulse_count_frame_decoder;
    localparam int DROP = 5;
    logic clk_sys;
    logic rst;
    logic carrier_present;
    pcfd_pkg::pcfd_analog_t analog_out;
    pcfd_pkg::pcfd_digital_t digital_out;
    logic read_strobe;
    logic clear_strobe;
    int miscompares = 0;
    int checked = 0;
    int w1cnt = 0;
    int w2cnt = 0;
    int rdcnt = 0;
    pcfd_decoder #(.SYNC_CYCLES(50)) pcfd_decoder_inst (.clk_sys(clk_sys), .rst(rst),
        .carrier_present(carrier_present), .analog_out(analog_out), .digital_out(digital_out),
        .read_strobe(read_strobe), .clear_strobe(clear_strobe));
    pcfd_tx_model #(.DROP(DROP)) pcfd_tx_model_inst (.clk_sys(clk_sys),
        .carrier_present(carrier_present));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        w1cnt <= w1cnt + analog_out.slot1;
        w2cnt <= w2cnt + analog_out.slot2;
        rdcnt <= rdcnt + read_strobe;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wait_strobes();
        repeat (300) if (read_strobe === 1'b1 || clear_strobe === 1'b1) @(negedge clk_sys);
        check(clear_strobe, 0);
    endtask
    task automatic frame_test(input int extra, input int w1, input int w2);
        int a1;
        int a2;
        a1 = w1cnt;
        a2 = w2cnt;
        pcfd_tx_model_inst.send_frame(extra, w1, w2);
        wait_strobes();
        check(digital_out, (extra - 1) & 3);
        check(w1cnt - a1, DROP + w1);
        check(w2cnt - a2, DROP + w2);
    endtask
    task automatic hold_test();
        int r;
        r = rdcnt;
        pcfd_tx_model_inst.slot(40);
        pcfd_tx_model_inst.slot(40);
        check(rdcnt - r, 0);
        check(digital_out, 2'h2);
        pcfd_tx_model_inst.slot(80);
        wait_strobes();
        check(digital_out, 2'h3);
    endtask
    initial begin
        rst = 1'b1;
        repeat (3) @(negedge clk_sys);
        rst <= 1'b0;
        repeat (300) @(negedge clk_sys);
        check(digital_out, 2'h0);
        frame_test(2, 20, 3);
        frame_test(4, 7, 12);
        frame_test(1, 1, 20);
        frame_test(3, 15, 9);
        hold_test();
        give_verdict();
    end
    initial begin
        #2000000;
        miscompares++;
        give_verdict();
    end
endmodule

// ===== rtl/pcfd_decoder.sv
`timescale 1ns/1ns
// Contract
// [R1] three-bit frame counter steps on every carrier falling edge; code ignores falling edges while clear_strobe is high
// [R2] sync timer held clear without carrier, runs only with carrier
// [R3] counter decode gives slot 1 and slot 2 analog pulses
// [R4] extra pulses after slot 2 counted, no analog output
// [R5] sync event when carrier present longer than timeout, 3.5 ms
// [R6] sync starts about 10 us read strobe loading counter low bits
// [R7] first output from bit 0, second from bit 1, held until next read
// [R8] after read strobe, 10 us clear strobe resets counter
// [R9] timeout exceeds longest channel interval, below shortest sync
// [R10] transmitter sync interval at least 5 ms for 3.5 ms timeout
// [R11] transmitter marks each channel boundary with 500 us dropout
// [R12] transmitter sends one to four fixed pulses after slot 2
// [R13] frame has one more falling edge than channels, 3 to 6 channels
// [R14] low bits 00,01,10,11 give off, first, second, both on
// [R15] clocked sampling, sync edges, cycle-count timeouts and strobes
module pcfd_decoder #(
    parameter int unsigned SYNC_CYCLES = pcfd_pkg::SYNC_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic carrier_present,
    output pcfd_pkg::pcfd_analog_t analog_out,
    output pcfd_pkg::pcfd_digital_t digital_out,
    output logic read_strobe,
    output logic clear_strobe
);
    // ------------------------------------------------------------
    // input edge detect
    // ------------------------------------------------------------
    logic carrier_d;
    logic fall;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            carrier_d <= 1'b0;
        end else begin
            carrier_d <= carrier_present; // see [R15]
        end
    end

    assign fall = carrier_d && !carrier_present;

    // ------------------------------------------------------------
    // sync timer
    // ------------------------------------------------------------
    logic sync_hit;
    logic sync_hit_d;
    logic sync_event;
    localparam logic [pcfd_pkg::TMR_W-1:0] SYNC_LIMIT = pcfd_pkg::TMR_W'(SYNC_CYCLES);

    pcfd_timer #(.W(pcfd_pkg::TMR_W)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .clear(!carrier_present), // see [R2]
        .run(carrier_present),
        .limit(SYNC_LIMIT),
        .expired(sync_hit)
    );

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync_hit_d <= 1'b0;
        end else begin
            sync_hit_d <= sync_hit;
        end
    end

    assign sync_event = sync_hit && !sync_hit_d; // see [R5] [R9]

    // ------------------------------------------------------------
    // strobe sequencer
    // ------------------------------------------------------------
    pcfd_pkg::pcfd_state_t state;
    logic [pcfd_pkg::STB_W-1:0] stb_cnt;
    localparam logic [pcfd_pkg::STB_W-1:0] STB_LAST = pcfd_pkg::STB_W'(pcfd_pkg::STROBE_CYCLES - 1);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= pcfd_pkg::PCFD_IDLE;
            stb_cnt <= '0;
        end else begin
            unique case (state)
                pcfd_pkg::PCFD_IDLE: begin
                    stb_cnt <= '0;
                    if (sync_event) begin
                        state <= pcfd_pkg::PCFD_READ; // see [R6]
                    end
                end
                pcfd_pkg::PCFD_READ: begin
                    if (stb_cnt == STB_LAST) begin
                        stb_cnt <= '0;
                        state <= pcfd_pkg::PCFD_CLEAR; // see [R8]
                    end else begin
                        stb_cnt <= stb_cnt + 1'b1;
                    end
                end
                pcfd_pkg::PCFD_CLEAR: begin
                    if (stb_cnt == STB_LAST) begin
                        stb_cnt <= '0;
                        state <= pcfd_pkg::PCFD_WAIT;
                    end else begin
                        stb_cnt <= stb_cnt + 1'b1;
                    end
                end
                pcfd_pkg::PCFD_WAIT: begin
                    stb_cnt <= '0;
                    state <= pcfd_pkg::PCFD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            read_strobe <= 1'b0;
            clear_strobe <= 1'b0;
        end else begin
            read_strobe <= (state == pcfd_pkg::PCFD_IDLE && sync_event)
                || (state == pcfd_pkg::PCFD_READ && stb_cnt != STB_LAST);
            clear_strobe <= (state == pcfd_pkg::PCFD_READ && stb_cnt == STB_LAST)
                || (state == pcfd_pkg::PCFD_CLEAR && stb_cnt != STB_LAST);
        end
    end

    // ------------------------------------------------------------
    // frame counter
    // ------------------------------------------------------------
    logic [pcfd_pkg::CNT_W-1:0] frame_count;

    always_ff @(posedge clk_sys) begin
        if (rst || clear_strobe) begin
            frame_count <= pcfd_pkg::COUNT_RST; // see [R8]
        end else if (fall) begin
            frame_count <= frame_count + 1'b1; // see [R1] [R4] [R13]
        end
    end

    // ------------------------------------------------------------
    // analog slot decode
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            analog_out <= '0;
        end else begin
            analog_out.slot1 <= (frame_count == pcfd_pkg::SLOT1_CODE); // see [R3]
            analog_out.slot2 <= (frame_count == pcfd_pkg::SLOT2_CODE); // see [R3] [R4]
        end
    end

    // ------------------------------------------------------------
    // digital latches
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            digital_out <= pcfd_pkg::DIG_RST;
        end else if (read_strobe) begin
            digital_out.first <= frame_count[0]; // see [R6] [R7] [R14]
            digital_out.second <= frame_count[1]; // see [R7] [R14]
        end
    end
endmodule

// ===== rtl/pcfd_pkg.sv
package pcfd_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned SYNC_TIMEOUT_US = 3500;
    localparam int unsigned STROBE_NS = 10_000;
    localparam int unsigned SYNC_CYCLES = SYNC_TIMEOUT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned STROBE_CYCLES = STROBE_NS / (1_000_000_000 / CLK_HZ);
    localparam int unsigned CNT_W = 3;
    localparam int unsigned TMR_W = 16;
    localparam int unsigned STB_W = 8;

    // ------------------------------------------------------------
    // slot codes and reset values
    // ------------------------------------------------------------
    localparam logic [2:0] SLOT1_CODE = 3'h1;
    localparam logic [2:0] SLOT2_CODE = 3'h2;
    localparam logic [2:0] COUNT_RST = 3'h0;
    localparam logic [1:0] DIG_RST = 2'h0;

    typedef enum logic [1:0] {PCFD_IDLE, PCFD_READ, PCFD_CLEAR, PCFD_WAIT} pcfd_state_t;

    typedef struct packed {
        logic slot1;
        logic slot2;
    } pcfd_analog_t;

    typedef struct packed {
        logic second;
        logic first;
    } pcfd_digital_t;
endpackage

// ===== rtl/pcfd_timer.sv
`timescale 1ns/1ns
module pcfd_timer #(
    parameter int unsigned W = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clear,
    input wire logic run,
    input wire logic [W-1:0] limit,
    output logic expired
);
    logic [W-1:0] count;

    always_ff @(posedge clk_sys) begin
        if (rst || clear) begin
            count <= '0;
        end else if (run && count != limit) begin
            count <= count + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || clear) begin
            expired <= 1'b0;
        end else begin
            expired <= run && (count + 1'b1 == limit || count == limit);
        end
    end
endmodule
